// File: src/bscan_pkg.sv
// Constants, states and state records of the boundary-scan test port.
package bscan_pkg;

   // Register widths and boundary chain shape.
   localparam int IR_W = 4;
   localparam int ID_W = 32;
   localparam int NUM_IN = 4;
   localparam int NUM_OUT = 4;
   localparam int BSR_W = NUM_IN + NUM_OUT;

   // Opcodes held in the opcode_register.
   localparam logic [3:0] OP_EXTEST = 4'h0;
   localparam logic [3:0] OP_SAMPLE = 4'h1;
   localparam logic [3:0] OP_IDCODE = 4'h2;
   localparam logic [3:0] OP_CLAMP = 4'h3;
   localparam logic [3:0] OP_HIGHZ = 4'h4;
   localparam logic [3:0] OP_BYPASS = 4'hf;
   // Fixed pattern loaded when the opcode_register captures.
   localparam logic [3:0] IR_CAPTURE = 4'h1;

   // Identification fields; revision, part and manufacturer values are arbitrary, the marker bit is one.
   localparam int ID_REV_LSB = 28;
   localparam int ID_PART_LSB = 12;
   localparam int ID_MFR_LSB = 1;
   localparam logic [3:0] ID_REV = 4'h1;
   localparam logic [15:0] ID_PART = 16'h5a5a;
   localparam logic [10:0] ID_MFR = 11'h2a5;
   localparam logic ID_MARK = 1'b1;
   localparam logic [31:0] ID_VALUE = {ID_REV, ID_PART, ID_MFR, ID_MARK};

   // Serial path selections.
   localparam logic [1:0] PATH_BYP = 2'h0;
   localparam logic [1:0] PATH_ID = 2'h1;
   localparam logic [1:0] PATH_BSR = 2'h2;

   // Test access controller states.
   typedef enum logic [3:0] {
      TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
      SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
      UP_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'ha, SH_IR = 4'hb,
      EX1_IR = 4'hc, PA_IR = 4'hd, EX2_IR = 4'he, UP_IR = 4'hf
   } tap_state_t;

   // All state clocked on the rising test clock.
   typedef struct packed {
      tap_state_t st;
      logic [3:0] ir_sh;
      logic [3:0] ir;
      logic byp;
      logic [ID_W-1:0] idsr;
      logic [BSR_W-1:0] boundary_cell_chain;
      logic [NUM_OUT-1:0] cells;
      logic drive;
      logic highz;
      logic upd_tgl;
      logic [NUM_IN-1:0] pin_s1;
      logic [NUM_IN-1:0] pin_s2;
      logic [NUM_OUT-1:0] core_s1;
      logic [NUM_OUT-1:0] core_s2;
   } tck_state_t;

   // Serial output state clocked on the falling test clock.
   typedef struct packed {
      logic tdo;
      logic tdo_oe_b;
   } tdo_state_t;

   // All state clocked on the system clock.
   typedef struct packed {
      logic drive_s1;
      logic drive_s2;
      logic hz_s1;
      logic hz_s2;
      logic tgl_s1;
      logic tgl_s2;
      logic tgl_seen;
      logic [NUM_OUT-1:0] cells;
      logic [NUM_OUT-1:0] pin_data;
      logic [NUM_OUT-1:0] pin_oe_b;
      logic [NUM_IN-1:0] in_s1;
      logic [NUM_IN-1:0] in_s2;
   } sys_state_t;

endpackage

// File: src/boundary_scan_test_port.sv
// Boundary-scan test access port with its boundary cell chain.
`timescale 1ns/1ps

// Contract
// RQ1 - Four-bit opcodes; all-ones selects single-bit passthrough.
// RQ2 - 0000: chain in path, cells drive outputs.
// RQ3 - 0010: load and shift 32-bit identity value.
// RQ4 - 0100: passthrough in path, outputs float.
// RQ5 - 0011: cells drive outputs, passthrough in path.
// RQ6 - 0001: chain captures pins and outputs.
// RQ7 - 0001: chain also preloads from serial input.
// RQ8 - Controller issues only the six defined opcodes.
// RQ9 - Output cells cover all outputs but TDO.
// RQ10 - Input cells cover inputs except test pins.
// RQ11 - Identity bits 31:28 hold revision field.
// RQ12 - Identity bits 27:12 hold part identifier.
// RQ13 - Identity bits 11:1 hold manufacturer code.
// RQ14 - Identity bit 0 always reads one.
// RQ15 - Controller runs test port at one rate.
// RQ16 - Sixteen-state controller; reset selects identity opcode.
module boundary_scan_test_port
   import bscan_pkg::*;
(
   // System clock, reset and enable.
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic clk_en_in,
   // Functional core side.
   input wire logic [NUM_OUT-1:0] core_data_in,
   input wire logic [NUM_OUT-1:0] core_oe_b_in,
   output logic [NUM_IN-1:0] core_in_out,
   // Functional pins.
   input wire logic [NUM_IN-1:0] pin_in,
   output logic [NUM_OUT-1:0] pin_data_out,
   output logic [NUM_OUT-1:0] pin_oe_b_out,
   // Serial test port.
   input wire logic tck_in,
   input wire logic trst_b_in,
   input wire logic tms_in,
   input wire logic tdi_in,
   output logic tdo_out,
   output logic tdo_oe_b_out
);

   ////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Standard sixteen-state walk, steered by mode select.
   function automatic tap_state_t next_tap(tap_state_t st, logic tms);
      case (st)
         TLR: next_tap = tms ? TLR : RTI;
         RTI: next_tap = tms ? SEL_DR : RTI;
         SEL_DR: next_tap = tms ? SEL_IR : CAP_DR;
         CAP_DR: next_tap = tms ? EX1_DR : SH_DR;
         SH_DR: next_tap = tms ? EX1_DR : SH_DR;
         EX1_DR: next_tap = tms ? UP_DR : PA_DR;
         PA_DR: next_tap = tms ? EX2_DR : PA_DR;
         EX2_DR: next_tap = tms ? UP_DR : SH_DR;
         UP_DR: next_tap = tms ? SEL_DR : RTI;
         SEL_IR: next_tap = tms ? TLR : CAP_IR;
         CAP_IR: next_tap = tms ? EX1_IR : SH_IR;
         SH_IR: next_tap = tms ? EX1_IR : SH_IR;
         EX1_IR: next_tap = tms ? UP_IR : PA_IR;
         PA_IR: next_tap = tms ? EX2_IR : PA_IR;
         EX2_IR: next_tap = tms ? UP_IR : SH_IR;
         UP_IR: next_tap = tms ? SEL_DR : RTI;
         default: next_tap = TLR;
      endcase
   endfunction

   // Which register an opcode puts between test data in and out.
   // Reserved codes fall back to the passthrough, the safest path.
   function automatic logic [1:0] path_of(logic [3:0] op);
      case (op)
         OP_EXTEST: path_of = PATH_BSR;
         OP_SAMPLE: path_of = PATH_BSR;
         OP_IDCODE: path_of = PATH_ID;
         default: path_of = PATH_BYP;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Test clock domain.

   tck_state_t t; // Rising-edge state.
   tck_state_t next_t; // Its next value.
   tdo_state_t o; // Falling-edge serial output.
   tdo_state_t next_o; // Its next value.

   // Controller, opcode, data registers and boundary chain.
   always_comb
   begin
      next_t = t;
      next_t.st = next_tap(t.st, tms_in); // RQ16
      // Pins and core outputs come from other domains: two flops.
      next_t.pin_s1 = pin_in; // RQ10
      next_t.pin_s2 = t.pin_s1;
      next_t.core_s1 = core_data_in; // RQ9
      next_t.core_s2 = t.core_s1;
      case (t.st)
         TLR:
         begin
            // Reset state selects the identity opcode, outputs free.
            next_t.ir = OP_IDCODE; // RQ16
            next_t.drive = 1'b0;
            next_t.highz = 1'b0;
         end
         CAP_IR:
         begin
            next_t.ir_sh = IR_CAPTURE;
         end
         SH_IR:
         begin
            next_t.ir_sh = {tdi_in, t.ir_sh[IR_W-1:1]}; // RQ1
         end
         UP_IR:
         begin
            // Mode flags are registered so they cross cleanly.
            next_t.ir = t.ir_sh; // RQ1
            next_t.drive = (t.ir_sh == OP_EXTEST) ||
               (t.ir_sh == OP_CLAMP); // RQ2 RQ5
            next_t.highz = (t.ir_sh == OP_HIGHZ); // RQ4
         end
         CAP_DR:
         begin
            case (path_of(t.ir))
               PATH_ID: next_t.idsr = ID_VALUE; // RQ3 RQ11 RQ12 RQ13 RQ14
               PATH_BSR: next_t.boundary_cell_chain = {t.pin_s2, t.core_s2}; // RQ6
               default: next_t.byp = 1'b0; // RQ1
            endcase
         end
         SH_DR:
         begin
            case (path_of(t.ir))
               PATH_ID: next_t.idsr = {tdi_in, t.idsr[ID_W-1:1]}; // RQ3
               PATH_BSR: next_t.boundary_cell_chain = {tdi_in, t.boundary_cell_chain[BSR_W-1:1]}; // RQ7
               default: next_t.byp = tdi_in; // RQ1
            endcase
         end
         UP_DR:
         begin
            // Only chain opcodes move shifted data into the cells.
            if (path_of(t.ir) == PATH_BSR)
            begin
               next_t.cells = t.boundary_cell_chain[NUM_OUT-1:0]; // RQ7
               next_t.upd_tgl = ~t.upd_tgl;
            end
         end
         default:
         begin
            next_t.st = next_t.st;
         end
      endcase
   end

   // Test reset clears the rising-edge state, except the opcode, which loads the identity opcode.
   always_ff @(posedge tck_in or negedge trst_b_in)
   begin
      if (!trst_b_in)
      begin
         t <= '0;
         t.ir <= OP_IDCODE; // RQ16
      end
      else
      begin
         t <= next_t;
      end
   end

   // Serial output: selected register's low bit, enabled in shift.
   always_comb
   begin
      next_o.tdo = o.tdo;
      next_o.tdo_oe_b = 1'b1;
      if (t.st == SH_IR)
      begin
         next_o.tdo = t.ir_sh[0];
         next_o.tdo_oe_b = 1'b0;
      end
      else if (t.st == SH_DR)
      begin
         next_o.tdo_oe_b = 1'b0;
         case (path_of(t.ir))
            PATH_ID: next_o.tdo = t.idsr[0]; // RQ3
            PATH_BSR: next_o.tdo = t.boundary_cell_chain[0]; // RQ6
            default: next_o.tdo = t.byp; // RQ1
         endcase
      end
   end

   // Output changes on the falling edge, half a period of margin.
   always_ff @(negedge tck_in or negedge trst_b_in)
   begin
      if (!trst_b_in)
      begin
         o <= '{tdo: 1'b0, tdo_oe_b: 1'b1};
      end
      else
      begin
         o <= next_o;
      end
   end

   assign tdo_out = o.tdo;
   assign tdo_oe_b_out = o.tdo_oe_b;

   ////////////////////////////////////////////////////////////////////
   // System clock domain.

   sys_state_t s; // System-side state.
   sys_state_t next_s; // Its next value.

   // Mode flags pass as levels; cell words pass by toggle handshake.
   // The test clock is far slower, so cells stay still long after
   // the toggle lands here.
   always_comb
   begin
      next_s = s;
      if (clk_en_in)
      begin
         next_s.drive_s1 = t.drive;
         next_s.drive_s2 = s.drive_s1;
         next_s.hz_s1 = t.highz;
         next_s.hz_s2 = s.hz_s1;
         next_s.tgl_s1 = t.upd_tgl;
         next_s.tgl_s2 = s.tgl_s1;
         next_s.in_s1 = pin_in;
         next_s.in_s2 = s.in_s1;
         if (s.tgl_s2 != s.tgl_seen)
         begin
            next_s.tgl_seen = s.tgl_s2;
            next_s.cells = t.cells;
         end
         if (s.hz_s2)
         begin
            // Every functional driver floats.
            next_s.pin_data = core_data_in;
            next_s.pin_oe_b = '1; // RQ4
         end
         else if (s.drive_s2)
         begin
            // Cell contents own every functional output.
            next_s.pin_data = next_s.cells; // RQ2 RQ5 RQ9
            next_s.pin_oe_b = '0;
         end
         else
         begin
            next_s.pin_data = core_data_in;
            next_s.pin_oe_b = core_oe_b_in;
         end
      end
   end

   // System reset leaves the pins floating until the core drives.
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         s <= '0;
         s.pin_oe_b <= '1;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign pin_data_out = s.pin_data;
   assign pin_oe_b_out = s.pin_oe_b;
   assign core_in_out = s.in_s2;

   ////////////////////////////////////////////////////////////////////
   // Assertions.

   // Opcode update step and data capture step.
   sequence upd_ir_s;
      t.st == UP_IR;
   endsequence
   sequence cap_dr_s;
      t.st == CAP_DR;
   endsequence

   reset_idcode_a: assert property ( // RQ16
      @(posedge tck_in) disable iff (!trst_b_in)
      (t.st == TLR) |=> (t.ir == OP_IDCODE) && !t.drive)
      else $error("reset state did not select identity opcode");

   byp_path_a: assert property ( // RQ1
      @(posedge tck_in) disable iff (!trst_b_in)
      (t.st == SH_DR && t.ir == OP_BYPASS) ##1 (t.st == SH_DR)
      |-> (o.tdo == $past(tdi_in)) && !o.tdo_oe_b)
      else $error("passthrough did not delay data one bit");

   id_load_a: assert property ( // RQ3
      @(posedge tck_in) disable iff (!trst_b_in)
      cap_dr_s ##0 (t.ir == OP_IDCODE) |=> (t.idsr == ID_VALUE))
      else $error("identity value not loaded on capture");

   id_rev_a: assert property ( // RQ11
      @(posedge tck_in) disable iff (!trst_b_in)
      cap_dr_s ##0 (t.ir == OP_IDCODE)
      |=> (t.idsr[ID_W-1:ID_REV_LSB] == ID_REV))
      else $error("revision field wrong");

   id_part_a: assert property ( // RQ12
      @(posedge tck_in) disable iff (!trst_b_in)
      cap_dr_s ##0 (t.ir == OP_IDCODE)
      |=> (t.idsr[ID_REV_LSB-1:ID_PART_LSB] == ID_PART))
      else $error("part field wrong");

   id_mfr_a: assert property ( // RQ13
      @(posedge tck_in) disable iff (!trst_b_in)
      cap_dr_s ##0 (t.ir == OP_IDCODE)
      |=> (t.idsr[ID_PART_LSB-1:ID_MFR_LSB] == ID_MFR) && t.idsr[0])
      else $error("manufacturer field or marker bit wrong");

   sample_cap_a: assert property ( // RQ6
      @(posedge tck_in) disable iff (!trst_b_in)
      cap_dr_s ##0 (t.ir == OP_SAMPLE)
      |=> (t.boundary_cell_chain == {$past(t.pin_s2), $past(t.core_s2)}))
      else $error("chain did not capture pins and outputs");

   preload_a: assert property ( // RQ7
      @(posedge tck_in) disable iff (!trst_b_in)
      (t.st == SH_DR && t.ir == OP_SAMPLE)
      |=> (t.boundary_cell_chain[BSR_W-1] == $past(tdi_in)))
      else $error("chain did not take serial input");

   clamp_mode_a: assert property ( // RQ5
      @(posedge tck_in) disable iff (!trst_b_in)
      upd_ir_s ##0 (t.ir_sh == OP_CLAMP)
      |=> t.drive && !t.highz && (path_of(t.ir) == PATH_BYP))
      else $error("clamp mode or path wrong");

   highz_pins_a: assert property ( // RQ4
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (clk_en_in && s.hz_s2) |=> (pin_oe_b_out == '1))
      else $error("outputs not floating in high impedance mode");

   drive_pins_a: assert property ( // RQ2
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (clk_en_in && s.drive_s2 && !s.hz_s2)
      |=> (pin_oe_b_out == '0) && (pin_data_out == s.cells))
      else $error("cells not driven onto outputs");

endmodule

// File: bench/tap_master.sv
// Model of the external test controller that drives the serial port.
`timescale 1ns/1ps

module tap_master
(
   // Serial port toward the device.
   output logic tck_out,
   output logic trst_b_out,
   output logic tms_out,
   output logic tdi_out,
   input wire logic tdo_in,
   input wire logic tdo_oe_b_in,
   // Bits seen during the last scan, and a toggle per finished scan.
   output logic [31:0] got_out,
   output logic got_tgl_out
);
   logic last; // Last serial output level that was seen.

   // Everything idles low; the test reset starts asserted.
   initial
   begin
      tck_out = 1'b0;
      trst_b_out = 1'b0;
      tms_out = 1'b0;
      tdi_out = 1'b0;
      got_out = '0;
      got_tgl_out = 1'b0;
      last = 1'b0;
   end

   // One test clock cycle, always 12 ns, and the clock stands low between
   // frames. A released output line reads as the inverse of its last level.
   task automatic tick(input logic tms, input logic tdi, output logic tdo);
      tms_out = tms;
      tdi_out = tdi;
      #6;
      tdo = tdo_oe_b_in ? ~last : tdo_in;
      last = tdo;
      tck_out = 1'b1;
      #6;
      tck_out = 1'b0;
   endtask

   // Test reset pulse, then one cycle into Run-Test/Idle.
   task automatic reset_tap();
      logic d;
      trst_b_out = 1'b0;
      #30;
      trst_b_out = 1'b1;
      #6;
      tick(1'b0, 1'b0, d);
   endtask

   // Scan n bits LSB first from Run-Test/Idle through Update back to Idle.
   task automatic scan(input logic ir, input int n, input logic [31:0] din);
      logic d;
      logic [31:0] q;
      q = '0;
      tick(1'b1, 1'b0, d);
      if (ir)
         tick(1'b1, 1'b0, d);
      tick(1'b0, 1'b0, d);
      tick(1'b0, 1'b0, d);
      for (int i = 0; i < n; i++)
      begin
         tick(i == n - 1, din[i], d);
         q[i] = d;
      end
      tick(1'b1, ~din[n-1], d);
      tick(1'b0, din[n-1], d);
      // The data line must not keep its level once the frame is over.
      tdi_out = ~tdi_out;
      got_out = q;
      got_tgl_out = ~got_tgl_out;
      // Let the result settle before anyone looks at it.
      #1;
   endtask
endmodule

// File: bench/test_boundary_scan_test_port.sv
// Self-checking bench for the boundary-scan test port.
`timescale 1ns/1ps

module test_boundary_scan_test_port
   import bscan_pkg::*;
   ;
   logic sys_clk, rst_b, clk_en, tck, trst_b, tms, tdi, tdo, tdo_oe_b;
   logic [3:0] core_data, core_oe_b, pin_data, pin_oe_b, pins, core_in;
   logic got_tgl;
   logic [31:0] got, seed, exp_v;
   logic [31:0] exp_q[$]; // Expected scan results, oldest first.
   logic [7:0] pre; // Pattern preloaded into the chain.
   logic [3:0] ops[4] = '{4'h3, 4'h4, 4'h3, 4'hf};
   int err_total = 0;
   int checked = 0;

   ////////////////////////////////////////////////////////////////////////
   // Clock, design and controller model.
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   boundary_scan_test_port DUT (.sys_clk_in(sys_clk), .rst_b_in(rst_b),
      .clk_en_in(clk_en), .core_data_in(core_data),
      .core_oe_b_in(core_oe_b), .core_in_out(core_in), .pin_in(pins),
      .pin_data_out(pin_data), .pin_oe_b_out(pin_oe_b), .tck_in(tck),
      .trst_b_in(trst_b), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo),
      .tdo_oe_b_out(tdo_oe_b));

   tap_master u_tap (.tck_out(tck), .trst_b_out(trst_b), .tms_out(tms),
      .tdi_out(tdi), .tdo_in(tdo), .tdo_oe_b_in(tdo_oe_b), .got_out(got),
      .got_tgl_out(got_tgl));

   ////////////////////////////////////////////////////////////////////////
   // Helpers.
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input logic [31:0] act, input logic [31:0] exp);
      checked++;
      if (act !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got %h exp %h", $time, act, exp);
      end
   endtask

   // Note the expectation first, so the watcher always finds it queued.
   task automatic scan_dr(input int n, input logic [31:0] d,
                          input logic [31:0] exp);
      exp_q.push_back(exp);
      u_tap.scan(1'b0, n, d);
   endtask

   // Opcode scans shift out the fixed capture pattern.
   task automatic load_ir(input logic [3:0] op);
      exp_q.push_back({28'h0, IR_CAPTURE});
      u_tap.scan(1'b1, 4, {28'h0, op});
   endtask

   // Pins settle within a few system cycles of a mode change.
   task automatic pins_are(input logic [3:0] oe_b, input logic [3:0] d);
      repeat (8) @(negedge sys_clk);
      check({28'h0, pin_oe_b}, {28'h0, oe_b});
      check({28'h0, pin_data}, {28'h0, d});
   endtask

   task automatic test_done();
      if (err_total == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Each finished scan is compared with the oldest queued expectation.
   always @(got_tgl)
   begin
      if ($time > 0)
      begin
         // Wait until the result word has settled at this level.
         #1;
         exp_v = exp_q.pop_front();
         check(got, exp_v);
      end
   end

   // A run takes about 3.2 us; stop a hang well after that.
   initial
   begin
      #200000;
      err_total++;
      test_done();
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      rst_b = 1'b0;
      clk_en = 1'b1;
      seed = 32'h7122;
      core_data = 4'h0;
      core_oe_b = 4'hf;
      pins = 4'h0;
      pre = 8'h00;
      repeat (10) @(negedge sys_clk);
      rst_b = 1'b1;
      seed = lfsr(lfsr(seed));
      core_data = seed[3:0];
      core_oe_b = seed[7:4];
      pins = seed[11:8];
      pre = seed[19:12];
      // Offset the test clock from the system clock edges.
      #1.3;
      u_tap.reset_tap();
      scan_dr(32, 32'h0, {ID_REV, ID_PART, ID_MFR, 1'b1});
      check({31'h0, got[0]}, 32'h1);
      check({20'h0, got[12 +: 12]}, {20'h0, ID_PART[11:0]});
      pins_are(core_oe_b, core_data);
      // A low enable freezes the pins while the core moves on.
      clk_en = 1'b0;
      core_data = ~core_data;
      pins_are(core_oe_b, ~core_data);
      clk_en = 1'b1;
      pins_are(core_oe_b, core_data);
      check({28'h0, core_in}, {28'h0, pins});
      // Sample the pins and preload the chain; nothing is driven yet.
      load_ir(4'h1);
      scan_dr(8, {24'h0, pre}, {24'h0, pins, core_data});
      pins_are(core_oe_b, core_data);
      // Preloaded cells go to the pins, then a fresh pattern replaces them.
      load_ir(4'h0);
      pins_are(4'h0, pre[3:0]);
      scan_dr(8, {24'h0, ~pre}, {24'h0, pins, core_data});
      pins_are(4'h0, ~pre[3:0]);
      // One-bit path opcodes only; reserved codes are never issued.
      foreach (ops[k])
      begin
         load_ir(ops[k]);
         scan_dr(8, {24'h0, pre}, {24'h0, pre[6:0], 1'b0});
         if (ops[k] == 4'h3)
            pins_are(4'h0, ~pre[3:0]);
         else if (ops[k] == 4'h4)
            pins_are(4'hf, core_data);
         else
            pins_are(core_oe_b, core_data);
      end
      // Test reset in mid-run drops drive mode and reselects identity.
      load_ir(4'h0);
      u_tap.reset_tap();
      pins_are(core_oe_b, core_data);
      scan_dr(32, 32'h0, {ID_REV, ID_PART, ID_MFR, 1'b1});
      #20;
      test_done();
   end
endmodule
